// ### memory_window_decode_regs.sv
/*
  Memory window register bank of the bridge with an AXI4-Lite slave and
  the address decode that decides which memory requests are forwarded.
  Assumes aclk-domain requesters drive mem_addr/mem_addr_valid and a
  single AXI4-Lite master.

  // Function
  // R1: Limit field 31:20 gives upper bound bits 31:20, low 20 bits ones.
  // R2: Base field 15:4 gives lower bound bits 31:20, low 20 bits zero.
  // R3: Memory window base and limit together select forwarded requests.
  // R4: Memory window reserved bits 19:16 and 3:0 read zero, read-only.
  // R5: Prefetch limit field 31:20 gives upper bound 31:20, low bits ones.
  // R6: Prefetch base field 15:4 gives lower bound 31:20, low bits zero.
  // R7: Prefetch register bits 19:16 and 3:0 read constant 1, read-only.
  // R8: Lower bound high register supplies prefetch lower bound bits 63:32.
  // R9: Upper bound high register supplies prefetch upper bound bits 63:32.
  // R10: Address inside window when lower <= address <= upper.
  // R11: Window with lower above upper is empty, forwards nothing.
*/
// Register access over AXI4-Lite was decided locally.
`default_nettype none
module memory_window_decode_regs
  import window_regs_pkg::*;
(
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [AXI_ADDR_W-1:0] s_awaddr,
  input  wire logic                  s_awvalid,
  output var  logic                  s_awready,
  input  wire logic [DATA_W-1:0]     s_wdata,
  input  wire logic [3:0]            s_wstrb,
  input  wire logic                  s_wvalid,
  output var  logic                  s_wready,
  output var  logic [1:0]            s_bresp,
  output var  logic                  s_bvalid,
  input  wire logic                  s_bready,
  input  wire logic [AXI_ADDR_W-1:0] s_araddr,
  input  wire logic                  s_arvalid,
  output var  logic                  s_arready,
  output var  logic [DATA_W-1:0]     s_rdata,
  output var  logic [1:0]            s_rresp,
  output var  logic                  s_rvalid,
  input  wire logic                  s_rready,
  input  wire logic [BOUND_W-1:0]    mem_addr,
  input  wire logic                  mem_addr_valid,
  output var  logic                  hit_valid,
  output var  logic                  mio_hit,
  output var  logic                  pref_hit
);
  typedef struct packed {
    logic                  awready;
    logic                  wready;
    logic                  aw_full;
    logic                  w_full;
    logic [AXI_ADDR_W-1:0] awaddr;
    logic [DATA_W-1:0]     wdata;
    logic [3:0]            wstrb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [DATA_W-1:0]     rdata;
    logic [1:0]            rresp;
    logic [DATA_W-1:0]     mio;
    logic [DATA_W-1:0]     pf;
    logic [DATA_W-1:0]     pf_lower_high;
    logic [DATA_W-1:0]     pf_upper_high;
    logic                  hit_valid;
    logic                  mio_hit;
    logic                  pref_hit;
  } state_t;

  localparam state_t STATE_RST = '{
    awready       : 1'b1,
    wready        : 1'b1,
    arready       : 1'b1,
    mio           : MIO_BOUNDS_RST,
    pf            : PF_BOUNDS_RST,
    pf_lower_high : HIGH_RST,
    pf_upper_high : HIGH_RST,
    default       : '0
  };

  state_t                  q;
  state_t                  next_q;
  logic                    wr_go;
  logic [AXI_ADDR_W-1:0]   wr_word;
  logic [AXI_ADDR_W-1:0]   rd_word;
  logic [BOUND_W-1:0]      mio_lower;
  logic [BOUND_W-1:0]      mio_upper;
  logic [BOUND_W-1:0]      pf_lower;
  logic [BOUND_W-1:0]      pf_upper;
  logic                    mio_in;
  logic                    pf_in;

  // Byte-lane merge that keeps read-only bits at their fixed value
  function automatic logic [DATA_W-1:0] merge_write(
    input logic [DATA_W-1:0] old_val,
    input logic [DATA_W-1:0] new_val,
    input logic [3:0]        strb,
    input logic [DATA_W-1:0] rw_mask,
    input logic [DATA_W-1:0] ro_val
  );
    logic [DATA_W-1:0] val;
    val = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        val[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return (val & rw_mask) | (ro_val & ~rw_mask);
  endfunction

  assign wr_go   = q.aw_full && q.w_full && !q.bvalid;
  assign wr_word = {q.awaddr[AXI_ADDR_W-1:2], 2'b00};
  assign rd_word = {s_araddr[AXI_ADDR_W-1:2], 2'b00};

  // 32-bit memory window: high words are zero
  window_bound_expand mio_expand (
    .window_reg  (q.mio),
    .lower_high  ({DATA_W{1'b0}}),
    .upper_high  ({DATA_W{1'b0}}),
    .lower_bound (mio_lower),
    .upper_bound (mio_upper)
  );

  window_bound_expand pf_expand (
    .window_reg  (q.pf),
    .lower_high  (q.pf_lower_high),
    .upper_high  (q.pf_upper_high),
    .lower_bound (pf_lower),
    .upper_bound (pf_upper)
  );

  window_addr_match #(.ADDR_W(BOUND_W)) mio_match (
    .addr        (mem_addr),
    .lower_bound (mio_lower),
    .upper_bound (mio_upper),
    .hit         (mio_in)
  );

  window_addr_match #(.ADDR_W(BOUND_W)) pf_match (
    .addr        (mem_addr),
    .lower_bound (pf_lower),
    .upper_bound (pf_upper),
    .hit         (pf_in)
  );

  always_comb begin
    next_q = q;
    // Write address and data are taken independently
    if (s_awvalid && q.awready) begin
      next_q.aw_full = 1'b1;
      next_q.awready = 1'b0;
      next_q.awaddr  = s_awaddr;
    end
    if (s_wvalid && q.wready) begin
      next_q.w_full = 1'b1;
      next_q.wready = 1'b0;
      next_q.wdata  = s_wdata;
      next_q.wstrb  = s_wstrb;
    end
    if (q.bvalid && s_bready) begin
      next_q.bvalid = 1'b0;
    end
    if (wr_go) begin
      next_q.aw_full = 1'b0;
      next_q.w_full  = 1'b0;
      next_q.awready = 1'b1;
      next_q.wready  = 1'b1;
      next_q.bvalid  = 1'b1;
      next_q.bresp   = RESP_OKAY;
      case (wr_word)
        MIO_BOUNDS_OFS: begin
          next_q.mio = merge_write(q.mio, q.wdata, q.wstrb,
                                   WINDOW_RW_MASK, MIO_RO_VAL); // see R4
        end
        PF_BOUNDS_OFS: begin
          next_q.pf = merge_write(q.pf, q.wdata, q.wstrb,
                                  WINDOW_RW_MASK, PF_RO_VAL); // see R7
        end
        PF_LOWER_HIGH_OFS: begin
          next_q.pf_lower_high = merge_write(q.pf_lower_high, q.wdata, q.wstrb,
                                             '1, '0); // see R8
        end
        PF_UPPER_HIGH_OFS: begin
          next_q.pf_upper_high = merge_write(q.pf_upper_high, q.wdata, q.wstrb,
                                             '1, '0); // see R9
        end
        default: begin
          next_q.bresp = RESP_SLVERR;
        end
      endcase
    end
    // Read channel: one read in flight, data captured at the address edge
    if (q.rvalid && s_rready) begin
      next_q.rvalid  = 1'b0;
      next_q.arready = 1'b1;
    end
    if (s_arvalid && q.arready) begin
      next_q.arready = 1'b0;
      next_q.rvalid  = 1'b1;
      next_q.rresp   = RESP_OKAY;
      case (rd_word)
        MIO_BOUNDS_OFS:    next_q.rdata = q.mio;
        PF_BOUNDS_OFS:     next_q.rdata = q.pf;
        PF_LOWER_HIGH_OFS: next_q.rdata = q.pf_lower_high;
        PF_UPPER_HIGH_OFS: next_q.rdata = q.pf_upper_high;
        default: begin
          next_q.rdata = '0;
          next_q.rresp = RESP_SLVERR;
        end
      endcase
    end
    // Forwarding decision, one cycle after the request address
    next_q.hit_valid = mem_addr_valid;
    next_q.mio_hit   = mem_addr_valid && mio_in; // see R3
    next_q.pref_hit  = mem_addr_valid && pf_in;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= STATE_RST;
    end else begin
      q <= next_q;
    end
  end

  assign s_awready = q.awready;
  assign s_wready  = q.wready;
  assign s_bresp   = q.bresp;
  assign s_bvalid  = q.bvalid;
  assign s_arready = q.arready;
  assign s_rdata   = q.rdata;
  assign s_rresp   = q.rresp;
  assign s_rvalid  = q.rvalid;
  assign hit_valid = q.hit_valid;
  assign mio_hit   = q.mio_hit;
  assign pref_hit  = q.pref_hit;

  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence full_write(logic [AXI_ADDR_W-1:0] ofs);
    wr_go && wr_word == ofs && q.wstrb == 4'hf;
  endsequence

  mio_upper_bound_a: assert property ( // see R1
    full_write(MIO_BOUNDS_OFS) |=> mio_upper[31:20] == $past(q.wdata[31:20])
      && mio_upper[19:0] == 20'hfffff)
    else $error("memory window upper bound not expanded from limit field");
  mio_lower_bound_a: assert property ( // see R2
    full_write(MIO_BOUNDS_OFS) |=> mio_lower[31:20] == $past(q.wdata[15:4])
      && mio_lower[19:0] == 20'h0 && mio_lower[63:32] == 32'h0)
    else $error("memory window lower bound not expanded from base field");
  mio_forward_a: assert property ( // see R3
    mem_addr_valid && mem_addr >= mio_lower && mem_addr <= mio_upper
      |=> hit_valid && mio_hit)
    else $error("address inside memory window not forwarded");
  mio_reserved_a: assert property ( // see R4
    s_arvalid && s_arready && rd_word == MIO_BOUNDS_OFS
      |=> s_rvalid && s_rdata[19:16] == 4'h0 && s_rdata[3:0] == 4'h0)
    else $error("memory window reserved bits not zero");
  pf_upper_bound_a: assert property ( // see R5
    full_write(PF_BOUNDS_OFS) |=> pf_upper[31:20] == $past(q.wdata[31:20])
      && pf_upper[19:0] == 20'hfffff)
    else $error("prefetch upper bound not expanded from limit field");
  pf_lower_bound_a: assert property ( // see R6
    full_write(PF_BOUNDS_OFS) |=> pf_lower[31:20] == $past(q.wdata[15:4])
      && pf_lower[19:0] == 20'h0)
    else $error("prefetch lower bound not expanded from base field");
  pf_width_cap_a: assert property ( // see R7
    s_arvalid && s_arready && rd_word == PF_BOUNDS_OFS
      |=> s_rvalid && s_rdata[19:16] == 4'h1 && s_rdata[3:0] == 4'h1)
    else $error("prefetch capability code not returned");
  pf_lower_high_a: assert property ( // see R8
    full_write(PF_LOWER_HIGH_OFS) |=> pf_lower[63:32] == $past(q.wdata))
    else $error("prefetch lower bound high word not applied");
  pf_upper_high_a: assert property ( // see R9
    full_write(PF_UPPER_HIGH_OFS) |=> pf_upper[63:32] == $past(q.wdata))
    else $error("prefetch upper bound high word not applied");
  pf_outside_a: assert property ( // see R10
    mem_addr_valid && (mem_addr < pf_lower || mem_addr > pf_upper) |=> !pref_hit)
    else $error("address outside prefetch window forwarded");
  empty_window_a: assert property ( // see R11
    mem_addr_valid && mio_lower > mio_upper |=> hit_valid && !mio_hit)
    else $error("inverted memory window forwarded a request");
  mio_outside_a: assert property ( // see R10
    mem_addr_valid && (mem_addr < mio_lower || mem_addr > mio_upper) |=> !mio_hit)
    else $error("address outside memory window forwarded");
  pf_inside_a: assert property ( // see R10
    mem_addr_valid && mem_addr >= pf_lower && mem_addr <= pf_upper |=> pref_hit)
    else $error("address inside prefetch window not forwarded");
  pf_empty_a: assert property ( // see R11
    mem_addr_valid && pf_lower > pf_upper |=> hit_valid && !pref_hit)
    else $error("inverted prefetch window forwarded a request");

  cover property (full_write(MIO_BOUNDS_OFS));
  cover property (s_rvalid && s_rready && s_rresp == RESP_SLVERR);
  cover property (mio_hit);
  cover property (pref_hit && pf_upper[63:32] != 32'h0);
endmodule
`default_nettype wire

// ### memory_window_decode_regs_tb_top.sv
/*
  Self-checking bench for the memory window register bank and decode.
  Assumes the bank answers as a single AXI4-Lite slave with a synchronous
  active-low reset, and that decode results follow one cycle after a request.
*/
`default_nettype none
module memory_window_decode_regs_tb_top
  import window_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk, aresetn, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready, req, mem_addr_valid;
  logic hit_valid, mio_hit, pref_hit;
  logic [7:0]  s_awaddr, s_araddr;
  logic [31:0] s_wdata, s_rdata, mreg, preg, lh, uh, seed;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp;
  logic [63:0] req_addr, mem_addr;
  int          miscompares, tests_run;

  memory_window_decode_regs i_memory_window_decode_regs (.aclk(aclk), .aresetn(aresetn),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata),
    .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(s_rready), .mem_addr(mem_addr), .mem_addr_valid(mem_addr_valid),
    .hit_valid(hit_valid), .mio_hit(mio_hit), .pref_hit(pref_hit));
  window_requester_model i_window_requester_model (.aclk(aclk), .req(req),
    .req_addr(req_addr), .mem_addr(mem_addr), .mem_addr_valid(mem_addr_valid));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [63:0] lo_of(input logic [31:0] w, input logic [31:0] h);
    return {h, w[15:4], 20'h0};
  endfunction
  function automatic logic [63:0] hi_of(input logic [31:0] w, input logic [31:0] h);
    return {h, w[31:20], 20'hfffff};
  endfunction
  function automatic logic in_win(input logic [63:0] lo, input logic [63:0] hi,
                                  input logic [63:0] a);
    return (lo <= a) && (a <= hi);
  endfunction

  task automatic print_verdict();
    $display("Counts: %0d comparisons, %0d mismatches", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: bus value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_hits(input logic [2:0] got, input logic [2:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: valid/mio/pref %b expected %b", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
                    input logic [1:0] er);
    int n;
    n = 0;
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= st;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
      if (s_bvalid) begin
        s_bready <= 1'b0;
        chk({30'h0, s_bresp}, {30'h0, er});
        n = 1000;
      end
    end
    if (n < 1000) begin
      miscompares++;
      $display("Error at %0t: write response timed out", $time);
    end
    // Idle edge so bready is never lowered and raised in one step
    @(posedge aclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (n < 100) begin
      @(posedge aclk);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
      if (s_rvalid) begin
        s_rready <= 1'b0;
        chk(s_rdata, ed);
        chk({30'h0, s_rresp}, {30'h0, er});
        n = 1000;
      end
    end
    if (n < 1000) begin
      miscompares++;
      $display("Error at %0t: read data timed out", $time);
    end
    // Idle edge so rready is never lowered and raised in one step
    @(posedge aclk);
  endtask
  task automatic probe(input logic [63:0] a);
    req <= 1'b1;
    req_addr <= a;
    @(posedge aclk);
    req <= 1'b0;
    @(posedge aclk);
    chk_hits({hit_valid, mio_hit, pref_hit}, {1'b1, in_win(lo_of(mreg, '0), hi_of(mreg, '0), a),
             in_win(lo_of(preg, lh), hi_of(preg, uh), a)});
  endtask
  task automatic probe_edges(input logic [63:0] lo, input logic [63:0] hi);
    probe(lo);
    probe(hi);
    probe(lo - 64'h1);
    probe(hi + 64'h1);
  endtask

  initial begin
    repeat (30000) @(posedge aclk);
    miscompares++;
    $display("Error at %0t: watchdog expired", $time);
    print_verdict();
  end

  initial begin
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, req} = '0;
    {s_awaddr, s_araddr, s_wdata, s_wstrb, req_addr} = '0;
    {miscompares, tests_run} = '0;
    aresetn = 1'b0;
    seed = 32'hc98f;
    mreg = MIO_BOUNDS_RST;
    preg = PF_BOUNDS_RST;
    lh = HIGH_RST;
    uh = HIGH_RST;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(MIO_BOUNDS_OFS, MIO_BOUNDS_RST, RESP_OKAY);
    rd(PF_BOUNDS_OFS, PF_BOUNDS_RST, RESP_OKAY);
    rd(PF_LOWER_HIGH_OFS, HIGH_RST, RESP_OKAY);
    rd(PF_UPPER_HIGH_OFS, HIGH_RST, RESP_OKAY);
    rd(8'h30, 32'h0, RESP_SLVERR);
    probe_edges(64'h0, 64'hfffff);
    $display("test reset done");
    wr(MIO_BOUNDS_OFS, 32'hffff_ffff, 4'hf, RESP_OKAY);
    rd(MIO_BOUNDS_OFS, 32'hfff0_fff0, RESP_OKAY);
    wr(PF_BOUNDS_OFS, 32'hfffe_fffe, 4'hf, RESP_OKAY);
    rd(PF_BOUNDS_OFS, 32'hfff1_fff1, RESP_OKAY);
    wr(MIO_BOUNDS_OFS, 32'h1234_5678, 4'h3, RESP_OKAY);
    rd(MIO_BOUNDS_OFS, 32'hfff0_5670, RESP_OKAY);
    wr(8'h40, 32'h0, 4'hf, RESP_SLVERR);
    $display("test access done");
    for (int i = 0; i < 24; i++) begin
      seed = lfsr(seed);
      mreg = seed;
      seed = lfsr(seed);
      preg = seed;
      seed = lfsr(seed);
      lh = seed & 32'h3;
      uh = (seed >> 2) & 32'h3;
      wr(MIO_BOUNDS_OFS, mreg, 4'hf, RESP_OKAY);
      wr(PF_BOUNDS_OFS, preg, 4'hf, RESP_OKAY);
      wr(PF_LOWER_HIGH_OFS, lh, 4'hf, RESP_OKAY);
      wr(PF_UPPER_HIGH_OFS, uh, 4'hf, RESP_OKAY);
      mreg = (mreg & WINDOW_RW_MASK) | MIO_RO_VAL;
      preg = (preg & WINDOW_RW_MASK) | PF_RO_VAL;
      rd(MIO_BOUNDS_OFS, mreg, RESP_OKAY);
      rd(PF_BOUNDS_OFS, preg, RESP_OKAY);
      rd(PF_UPPER_HIGH_OFS, uh, RESP_OKAY);
      probe_edges(lo_of(mreg, '0), hi_of(mreg, '0));
      probe_edges(lo_of(preg, lh), hi_of(preg, uh));
      probe({lh, seed});
    end
    $display("test window done");
    print_verdict();
  end
endmodule
`default_nettype wire

// ### window_addr_match.sv
/*
  Inclusive address window compare. Assumes bounds already expanded to
  full width; an inverted window never matches.
*/
`default_nettype none
module window_addr_match #(
  parameter int ADDR_W = 64
) (
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [ADDR_W-1:0] lower_bound,
  input  wire logic [ADDR_W-1:0] upper_bound,
  output logic                   hit
);
  assign hit = (lower_bound <= upper_bound) // see R11
            && (addr >= lower_bound) && (addr <= upper_bound); // see R10
endmodule
`default_nettype wire

// ### window_bound_expand.sv
/*
  Expands a base/limit window register and the two high words into full
  64-bit lower and upper bounds. Purely combinational; the caller passes
  zero high words for a 32-bit window.
*/
`default_nettype none
module window_bound_expand
  import window_regs_pkg::*;
(
  input  wire logic [DATA_W-1:0]  window_reg,
  input  wire logic [DATA_W-1:0]  lower_high,
  input  wire logic [DATA_W-1:0]  upper_high,
  output logic      [BOUND_W-1:0] lower_bound,
  output logic      [BOUND_W-1:0] upper_bound
);
  // Limit field fills the low bits with ones, base field with zeros
  assign upper_bound = {upper_high, window_reg[UPPER_FIELD_LSB +: FIELD_W],
                        {LOW_BITS_W{1'b1}}}; // see R1 see R5 see R9
  assign lower_bound = {lower_high, window_reg[LOWER_FIELD_LSB +: FIELD_W],
                        {LOW_BITS_W{1'b0}}}; // see R2 see R6 see R8
endmodule
`default_nettype wire

// ### window_regs_pkg.sv
/*
  Shared constants for the memory window register bank: register byte
  offsets, reset values, field positions and bus response codes.
  Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
*/
`default_nettype none
package window_regs_pkg;
  localparam int AXI_ADDR_W = 8;
  localparam int DATA_W     = 32;
  localparam int BOUND_W    = 64;

  // Register byte offsets
  localparam logic [AXI_ADDR_W-1:0] MIO_BOUNDS_OFS    = 8'h20;
  localparam logic [AXI_ADDR_W-1:0] PF_BOUNDS_OFS     = 8'h24;
  localparam logic [AXI_ADDR_W-1:0] PF_LOWER_HIGH_OFS = 8'h28;
  localparam logic [AXI_ADDR_W-1:0] PF_UPPER_HIGH_OFS = 8'h2c;

  // Reset values
  localparam logic [DATA_W-1:0] MIO_BOUNDS_RST = 32'h0000_0000;
  localparam logic [DATA_W-1:0] PF_BOUNDS_RST  = 32'h0001_0001;
  localparam logic [DATA_W-1:0] HIGH_RST       = 32'h0000_0000;

  // Writable bits of both window registers and their fixed read-only parts
  localparam logic [DATA_W-1:0] WINDOW_RW_MASK = 32'hfff0_fff0;
  localparam logic [DATA_W-1:0] MIO_RO_VAL     = 32'h0000_0000;
  localparam logic [DATA_W-1:0] PF_RO_VAL      = 32'h0001_0001;

  // Field layout: upper_bound_field at 31:20, lower field at 15:4,
  // pref_top_width_cap at 19:16 and the lower-bound capability at 3:0
  localparam int UPPER_FIELD_LSB = 20;
  localparam int LOWER_FIELD_LSB = 4;
  localparam int FIELD_W         = 12;
  localparam int LOW_BITS_W      = 20;
  localparam int TOP_CAP_LSB     = 16;
  localparam int BASE_CAP_LSB    = 0;
  localparam int CAP_W           = 4;
  localparam logic [CAP_W-1:0] CAP_64BIT = 4'h1;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage
`default_nettype wire

// ### window_requester_model.sv
/*
  Model of the aclk-domain requester that feeds the window decode.
  Assumes the bench asks for one lookup per cycle by holding req high.
*/
`default_nettype none
module window_requester_model
  import window_regs_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               req,
  input  wire logic [BOUND_W-1:0] req_addr,
  output logic      [BOUND_W-1:0] mem_addr,
  output logic                    mem_addr_valid
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [BOUND_W-1:0] last = '0;
  always_ff @(posedge aclk) if (req) last <= req_addr;
  // Idle bus shows the inverse of the last address, never a stale copy
  assign mem_addr       = req ? req_addr : ~last;
  assign mem_addr_valid = req;
endmodule
`default_nettype wire
